// ### verilog/tic_pkg.sv
// Constants and register layout of the tamper input control block.
package tic_pkg;
  localparam int          NCH             = 5;
  localparam logic [11:0] ADDR_CTRL       = 12'h060;
  localparam logic [11:0] ADDR_ENABLE     = 12'h064;
  localparam logic [11:0] ADDR_STATUS     = 12'h068;
  localparam logic [11:0] ADDR_MASK       = 12'h06c;
  localparam logic [11:0] ADDR_STAMP      = 12'h070;
  localparam logic [11:0] ADDR_COUNTER    = 12'h074;
  localparam int          ACT_LSB         = 0;
  localparam int          POL_LSB         = 16;
  localparam int          DEB_LSB         = 24;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK      = 32'h1f1f_03ff;
  localparam logic [1:0]  ACT_OFF         = 2'h0;
  localparam logic [1:0]  ACT_WAKE        = 2'h1;
  localparam logic [1:0]  ACT_CAPTURE     = 2'h2;
  localparam logic [1:0]  ACT_COMPARE     = 2'h3;
  localparam int          DEB_CYCLES      = 4;
  localparam logic [2:0]  DEB_CYCLES_W    = 3'h4;
  localparam int          LAYER_DIV       = 16;
  localparam logic [3:0]  LAYER_DIV_MAX   = 4'hf;
  localparam int          LAYER_SETTLE    = 2;
  localparam logic [3:0]  LAYER_SAMPLE_AT = 4'h7;
endpackage

// ### verilog/tic_channel.sv
// One tamper input channel: debounce, edge detect and layer compare.
`timescale 1ns/1ns
`default_nettype none
module tic_channel
  import tic_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       pin_in,
  input  wire logic       layer_out,
  input  wire logic       sample_en,
  input  wire logic       deb_en,
  input  wire logic       pol_rise,
  input  wire logic [1:0] action,
  output logic            event_pulse
);
  logic [2:0] cnt_q;
  logic       stable_q;
  logic       level_q;
  logic       filt;
  logic       edge_hit;

  // A change must hold for the full count before the filtered level follows.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q    <= 3'h0;
      stable_q <= 1'b0;
    end else if (pin_in == stable_q) begin
      cnt_q <= 3'h0;
    end else if (cnt_q == DEB_CYCLES_W - 3'h1) begin
      cnt_q    <= 3'h0;
      stable_q <= pin_in;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  assign filt = deb_en ? stable_q : pin_in;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= 1'b0;
    end else begin
      level_q <= filt;
    end
  end

  assign edge_hit = pol_rise ? (filt & ~level_q) : (~filt & level_q);

  // The returning layer is only checked mid-period so wire delay never reads as a mismatch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_pulse <= 1'b0;
    end else begin
      case (action)
        ACT_OFF:     event_pulse <= 1'b0;
        ACT_WAKE:    event_pulse <= edge_hit;
        ACT_CAPTURE: event_pulse <= edge_hit;
        ACT_COMPARE: event_pulse <= sample_en & (filt != layer_out);
        default:     event_pulse <= 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### verilog/tic_top.sv
// Tamper input control block with APB register access.
`timescale 1ns/1ns
`default_nettype none
module tic_top
  import tic_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              write_guard,
  input  wire logic [NCH-1:0]    tamper_input_n,
  output logic      [NCH-1:0]    layer_out_n,
  output logic                   wake_req,
  output logic                   stamp_strobe,
  output logic                   irq
);
  logic [31:0]    tamper_control_q;
  logic           enable_q;
  logic [NCH-1:0] status_q;
  logic [NCH-1:0] mask_q;
  logic [31:0]    counter_q;
  logic [31:0]    stamp_q;
  logic [3:0]     div_q;
  logic           layer_q;
  logic [NCH-1:0] ev;
  logic [NCH-1:0] wake_hit;
  logic [NCH-1:0] stamp_hit;
  logic           sample_en;
  logic           wr_en;
  logic           rd_en;
  logic           addr_ok;

  assign wr_en     = psel & penable & pwrite & ~pready;
  assign rd_en     = psel & penable & ~pwrite & ~pready;
  assign sample_en = (div_q == LAYER_SAMPLE_AT);
  assign addr_ok   = (paddr == ADDR_CTRL) | (paddr == ADDR_ENABLE) | (paddr == ADDR_STATUS)
                   | (paddr == ADDR_MASK) | (paddr == ADDR_STAMP) | (paddr == ADDR_COUNTER);

  // Free running time base that the timestamp captures.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_q <= 32'h0;
    end else begin
      counter_q <= counter_q + 32'h1;
    end
  end

  // Divider makes the square wave sent round the protective layer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q   <= 4'h0;
      layer_q <= 1'b0;
    end else begin
      div_q <= div_q + 4'h1;
      if (div_q == LAYER_DIV_MAX) begin
        layer_q <= ~layer_q;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      layer_out_n <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        layer_out_n[i] <= (tamper_control_q[ACT_LSB+2*i +: 2] == ACT_COMPARE) ? layer_q : 1'b0;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      tic_channel u_ch (
        .pclk        (pclk),
        .presetn     (presetn),
        .pin_in      (tamper_input_n[g]),
        .layer_out   (layer_out_n[g]),
        .sample_en   (sample_en),
        .deb_en      (tamper_control_q[DEB_LSB+g]),
        .pol_rise    (tamper_control_q[POL_LSB+g]),
        .action      (enable_q ? tamper_control_q[ACT_LSB+2*g +: 2] : ACT_OFF),
        .event_pulse (ev[g])
      );
      assign wake_hit[g]  = ev[g] & (tamper_control_q[ACT_LSB+2*g +: 2] == ACT_WAKE);
      assign stamp_hit[g] = ev[g] & (tamper_control_q[ACT_LSB+2*g +: 2] != ACT_WAKE);
    end
  endgenerate

  // Control only changes while the block is disabled and the guard is open.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tamper_control_q <= CTRL_RESET;
    end else if (wr_en && paddr == ADDR_CTRL && !enable_q && !write_guard) begin
      tamper_control_q <= pwdata & CTRL_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= 1'b0;
      mask_q   <= '0;
    end else if (wr_en && !write_guard) begin
      if (paddr == ADDR_ENABLE) begin
        enable_q <= pwdata[0];
      end
      if (paddr == ADDR_MASK) begin
        mask_q <= pwdata[NCH-1:0];
      end
    end
  end

  // A new event wins over a write-one clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~((wr_en && paddr == ADDR_STATUS) ? pwdata[NCH-1:0] : '0)) | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stamp_q      <= 32'h0;
      stamp_strobe <= 1'b0;
      wake_req     <= 1'b0;
      irq          <= 1'b0;
    end else begin
      stamp_strobe <= |stamp_hit;
      wake_req     <= |wake_hit;
      irq          <= |(status_q & mask_q);
      if (|stamp_hit) begin
        stamp_q <= counter_q;
      end
    end
  end

  // Every access completes in one wait cycle; unmapped addresses give an error and read zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & (~addr_ok | (pwrite & write_guard));
      prdata  <= 32'h0;
      if (rd_en) begin
        case (paddr)
          ADDR_CTRL:    prdata <= tamper_control_q;
          ADDR_ENABLE:  prdata <= {31'h0, enable_q};
          ADDR_STATUS:  prdata <= {27'h0, status_q};
          ADDR_MASK:    prdata <= {27'h0, mask_q};
          ADDR_STAMP:   prdata <= stamp_q;
          ADDR_COUNTER: prdata <= counter_q;
          default:      prdata <= 32'h0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ### sim/tic_pins.sv
// Model of the tamper switches and protective loops on the pins.
`timescale 1ns/1ns
`default_nettype none
module tic_pins (
  input  wire logic       pclk,
  input  wire logic [4:0] layer_out_n,
  input  wire logic [4:0] level,
  input  wire logic [4:0] loop,
  input  wire logic [4:0] cut,
  output var  logic [4:0] pins = 5'h1d
);
  // A loop returns the wave a cycle late; a cut loop returns its inverse.
  always @(posedge pclk) pins <= loop & (layer_out_n ^ cut) | ~loop & level;
endmodule
`default_nettype wire

// ### sim/tic_top_assertions.sv
// Port assertions of the tamper input control block.
`timescale 1ns/1ns
`default_nettype none
module tic_top_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        write_guard,
  input wire logic        wake_req,
  input wire logic        stamp_strobe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wait; psel && penable && !pready; endsequence
  sequence s_done; psel && penable && pready; endsequence
  property p_answer; s_wait |=> pready; endproperty
  property p_once; pready |=> !pready; endproperty
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  property p_guard; s_done ##0 (pwrite && write_guard) |-> pslverr; endproperty
  property p_err; pslverr |-> s_done; endproperty
  property p_unmap; pslverr && !pwrite |-> prdata == 32'h0; endproperty
  property p_wake; wake_req |=> !wake_req; endproperty
  property p_stamp; stamp_strobe |=> !stamp_strobe; endproperty
  a_answer: assert property (p_answer) else $error("late answer");
  a_once: assert property (p_once) else $error("long ready");
  a_idle: assert property (p_idle) else $error("stray read data");
  a_guard: assert property (p_guard) else $error("guarded write accepted");
  a_err: assert property (p_err) else $error("stray error");
  a_unmap: assert property (p_unmap) else $error("unmapped data");
  a_wake: assert property (p_wake) else $error("long wake");
  a_stamp: assert property (p_stamp) else $error("long stamp");
endmodule
`default_nettype wire

// ### sim/tic_top_tb.sv
// Self-checking bench of the tamper input control block.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin bad_count++; $display("wrong value %0t %h %h", $time, a, e); end end
module tic_top_tb
  import tic_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, write_guard = 0;
  logic pready, pslverr, wake_req, stamp_strobe, irq, err, lo;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, c0;
  logic [NCH-1:0] tamper_input_n, layer_out_n, level = 5'h1d, loop = 0, cut = 0;
  int bad_count = 0, compares = 0, nw, ns;
  always #25 pclk = ~pclk;
  tic_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .write_guard, .tamper_input_n, .layer_out_n, .wake_req, .stamp_strobe, .irq);
  tic_pins pins (.pclk, .layer_out_n, .level, .loop, .cut, .pins(tamper_input_n));
  task automatic conclude(input int extra);
    bad_count += extra;
    if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // The request is held until ready is seen high, for at most 20 cycles, so a slow answer needs no special case.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk);
    while (pready !== 1'h1 && ++n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 20) conclude(1);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'h0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic watch(input int cyc);
    nw = 0;
    ns = 0;
    repeat (cyc) begin
      @(posedge pclk);
      nw += int'(wake_req === 1'h1);
      ns += int'(stamp_strobe === 1'h1);
    end
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    rdchk(ADDR_CTRL, 32'h0);
    xfer(1'h1, ADDR_CTRL, 32'hffff_ffff);
    rdchk(ADDR_CTRL, 32'h1f1f_03ff);
    write_guard <= 1'h1;
    xfer(1'h1, ADDR_CTRL, 32'h0);
    `CHK(err, 1'h1)
    write_guard <= 1'h0;
    rdchk(ADDR_CTRL, 32'h1f1f_03ff);
    rdchk(12'h0fc, 32'h0);
    `CHK(err, 1'h1)
    xfer(1'h1, ADDR_CTRL, 32'h0202_0039);
    xfer(1'h1, ADDR_MASK, 32'h1f);
    loop <= 5'h04;
    xfer(1'h1, ADDR_ENABLE, 32'h1);
    xfer(1'h1, ADDR_CTRL, 32'h0);
    rdchk(ADDR_CTRL, 32'h0202_0039);
    `CHK(layer_out_n & 5'h1b, 5'h0)
    // The wave toggles once every sixteen cycles, so sixteen cycles on it must be inverted.
    lo = layer_out_n[2];
    watch(16);
    `CHK(layer_out_n[2], ~lo)
    level <= 5'h15;
    watch(40);
    `CHK(nw + ns, 0)
    level <= 5'h14;
    watch(10);
    `CHK(nw, 1)
    `CHK(irq, 1'h1)
    rdchk(ADDR_STATUS, 32'h1);
    xfer(1'h1, ADDR_MASK, 32'h0);
    watch(3);
    `CHK(irq, 1'h0)
    xfer(1'h1, ADDR_STATUS, 32'h1);
    xfer(1'h1, ADDR_MASK, 32'h1f);
    watch(3);
    `CHK(irq, 1'h0)
    level <= 5'h16;
    watch(2);
    level <= 5'h14;
    watch(12);
    `CHK(ns, 0)
    level <= 5'h16;
    watch(14);
    `CHK(ns, 1)
    // Pin change, four stable cycles and two register stages put the capture 14 counts before the counter read.
    xfer(1'h0, ADDR_STAMP, 32'h0);
    c0 = rd;
    xfer(1'h0, ADDR_COUNTER, 32'h0);
    `CHK(rd - c0, 32'h0000_000e)
    cut <= 5'h04;
    watch(40);
    `CHK(ns != 0, 1'h1)
    rdchk(ADDR_STATUS, 32'h6);
    conclude(0);
  end
endmodule
bind tic_top tic_top_assertions chk (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready,
  .pslverr, .write_guard, .wake_req, .stamp_strobe);
`undef CHK
`default_nettype wire
